// ==== gate_pkg.sv ====
package gate_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PRIV = 8'h08;
    localparam logic [7:0] OFF_GSEL = 8'h0C;
    localparam logic [7:0] OFF_GOFF_LO = 8'h10;
    localparam logic [7:0] OFF_GOFF_HI = 8'h14;
    localparam logic [7:0] OFF_SS = 8'h18;
    localparam logic [7:0] OFF_SP_LO = 8'h1C;
    localparam logic [7:0] OFF_SP_HI = 8'h20;
    localparam logic [7:0] OFF_CS = 8'h24;
    localparam logic [7:0] OFF_IP_LO = 8'h28;
    localparam logic [7:0] OFF_IP_HI = 8'h2C;
    localparam logic [7:0] OFF_STK_BASE = 8'h30;
    localparam logic [7:0] OFF_STK_END = 8'h5C;
    localparam logic [1:0] STK_WORD_LO = 2'h0;
    localparam logic [1:0] STK_WORD_HI = 2'h1;
    localparam logic [1:0] STK_WORD_SEL = 2'h2;
    localparam int CTRL_START = 0;
    localparam int CTRL_LONG = 1;
    localparam int CTRL_JUMP = 2;
    localparam int CTRL_CONF = 3;
    localparam int CTRL_GATE32 = 4;
    localparam int CTRL_TGT64 = 5;
    localparam int PRIV_CUR = 0;
    localparam int PRIV_REQ = 2;
    localparam int PRIV_GATE = 4;
    localparam int PRIV_TGT = 6;
    localparam int PRIV_CNT = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_FAILED = 4;
    localparam int ST_PRIV = 8;
    localparam logic [1:0] SHIFT_16 = 2'h1;
    localparam logic [1:0] SHIFT_32 = 2'h2;
    localparam logic [1:0] SHIFT_64 = 2'h3;
    localparam logic [15:0] NULL_SEL = 16'h0000;
    localparam logic [2:0] ALL_PASS = 3'h7;
    typedef enum logic [3:0] {
        P_IDLE, P_CHECK, P_PUSH_SS, P_PUSH_SP, P_READ, P_PUSH_PARAM, P_PUSH_CS, P_PUSH_IP, P_COMMIT
    } phase_t;
endpackage : gate_pkg

// ==== priv_check_if.sv ====
interface priv_check_if;
    logic [1:0] current_privilege_level;
    logic [1:0] requested_privilege;
    logic [1:0] gate_priv;
    logic [1:0] target_priv;
    logic is_jump;
    logic conforming;
    logic [2:0] pass;
    modport chk (input current_privilege_level, requested_privilege, gate_priv, target_priv,
        is_jump, conforming, output pass);
    modport req (output current_privilege_level, requested_privilege, gate_priv, target_priv,
        is_jump, conforming, input pass);
endinterface : priv_check_if

// ==== gate_priv_check.sv ====
module gate_priv_check (
    priv_check_if.chk pc
);
    assign pc.pass[0] = pc.current_privilege_level <= pc.gate_priv;
    assign pc.pass[1] = pc.requested_privilege <= pc.gate_priv;
    // a jump never raises privilege, so a nonconforming target must match exactly
    assign pc.pass[2] = (pc.is_jump && !pc.conforming)
        ? (pc.current_privilege_level == pc.target_priv)
        : (pc.current_privilege_level >= pc.target_priv);
endmodule : gate_priv_check

// ==== call_gate_unit.sv ====
// Operation
// - long mode needs 64-bit target code segment
// - long mode target address is gate offset
// - three privilege checks before loading code selector
// - current privilege at most gate privilege
// - requested privilege at most gate privilege
// - call or conforming jump: current at least target
// - nonconforming jump: current equals target privilege
// - any failed check denies entry
// - privilege change switches to new stack
// - legacy: target privilege selects stack entry
// - legacy: load new stack, push old one
// - legacy: copy gate count parameters
// - parameter width four or two bytes
// - legacy: push return, load gate target
// - long: target privilege selects 64-bit pointer
// - long: stack selector becomes null
// - stack selector requested privilege equals new
// - long: push old selector and pointer
// - long: push return, load gate target
// - long pushes eight bytes each
// - long mode ignores count, copies nothing
// - long entries hold pointer only
// - long: 16-bit gates illegal
//
// The APB interface to the registers and the register offsets are this design's own decisions.
module call_gate_unit
    import gate_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic mem_we,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata,
    output logic [3:0] mem_size,
    input wire logic mem_ready,
    input wire logic [63:0] mem_rdata,
    output logic gate_busy,
    output logic gate_fault
);
    typedef struct packed {
        phase_t phase;
        logic long_mode;
        logic is_jump;
        logic conforming;
        logic gate32;
        logic tgt64;
        logic [1:0] current_privilege_level;
        logic [1:0] requested_privilege;
        logic [1:0] gpriv;
        logic [1:0] tpriv;
        logic [4:0] count;
        logic [15:0] gsel;
        logic [63:0] goff;
        logic [15:0] ss;
        logic [63:0] sp;
        logic [15:0] cs;
        logic [63:0] ip;
        logic [2:0][63:0] lvl_sp;
        logic [2:0][15:0] lvl_sel;
        logic busy;
        logic done;
        logic fault;
        logic [2:0] failed;
        logic change;
        logic [1:0] new_priv;
        logic [63:0] wsp;
        logic [4:0] idx;
        logic [63:0] pdata;
        logic mem_req;
        logic mem_we;
        logic [63:0] mem_addr;
        logic [63:0] mem_wdata;
        logic [3:0] mem_size;
        logic [31:0] rdata;
        logic slverr;
    } state_t;

    state_t state_reg;
    state_t state_next;
    priv_check_if pc ();

    gate_priv_check u_check (
        .pc(pc.chk)
    );

    assign pc.current_privilege_level = state_reg.current_privilege_level;
    assign pc.requested_privilege = state_reg.requested_privilege;
    assign pc.gate_priv = state_reg.gpriv;
    assign pc.target_priv = state_reg.tpriv;
    assign pc.is_jump = state_reg.is_jump;
    assign pc.conforming = state_reg.conforming;

    // push width as a shift: long 8 bytes, else by gate size
    function automatic logic [1:0] push_shift(input logic long_mode, input logic gate32);
        if (long_mode)
            push_shift = SHIFT_64;
        else
            push_shift = gate32 ? SHIFT_32 : SHIFT_16;
    endfunction : push_shift

    function automatic logic [63:0] entry_sp(input state_t s, input logic [1:0] lvl);
        case (lvl)
            2'h0: entry_sp = s.lvl_sp[0];
            2'h1: entry_sp = s.lvl_sp[1];
            default: entry_sp = s.lvl_sp[2];
        endcase
    endfunction : entry_sp

    function automatic logic [15:0] entry_sel(input state_t s, input logic [1:0] lvl);
        case (lvl)
            2'h0: entry_sel = s.lvl_sel[0];
            2'h1: entry_sel = s.lvl_sel[1];
            default: entry_sel = s.lvl_sel[2];
        endcase
    endfunction : entry_sel

    always_comb
    begin
        logic [1:0] sh;
        logic [63:0] psz;
        logic [63:0] pval;
        phase_t after;
        logic [1:0] lvl;
        logic stk_hit;
        logic [63:0] apb_sp;
        logic [63:0] tgt_sp;
        logic [15:0] tgt_sel;
        state_next = state_reg;
        sh = push_shift(state_reg.long_mode, state_reg.gate32);
        psz = 64'h1 << sh;
        pval = 64'h0;
        after = P_IDLE;
        lvl = 2'(paddr[5:4] - OFF_STK_BASE[5:4]);
        stk_hit = (paddr >= OFF_STK_BASE) && (paddr <= OFF_STK_END) && (paddr[3:2] != 2'h3)
            && (paddr[1:0] == 2'h0);
        apb_sp = entry_sp(state_reg, lvl);
        tgt_sp = entry_sp(state_reg, state_reg.tpriv);
        tgt_sel = entry_sel(state_reg, state_reg.tpriv);

        // setup phase: latch read data and error so the access phase answers from flops
        if (psel && !penable)
        begin
            state_next.slverr = 1'b0;
            state_next.rdata = 32'h0;
            case (paddr)
                OFF_CTRL: state_next.rdata = {26'h0, state_reg.tgt64, state_reg.gate32,
                    state_reg.conforming, state_reg.is_jump, state_reg.long_mode, 1'b0};
                OFF_STATUS: state_next.rdata = {22'h0, state_reg.current_privilege_level, 1'b0,
                    state_reg.failed, 1'b0, state_reg.fault, state_reg.done, state_reg.busy};
                OFF_PRIV: state_next.rdata = {19'h0, state_reg.count, state_reg.tpriv,
                    state_reg.gpriv, state_reg.requested_privilege,
                    state_reg.current_privilege_level};
                OFF_GSEL: state_next.rdata = {16'h0, state_reg.gsel};
                OFF_GOFF_LO: state_next.rdata = state_reg.goff[31:0];
                OFF_GOFF_HI: state_next.rdata = state_reg.goff[63:32];
                OFF_SS: state_next.rdata = {16'h0, state_reg.ss};
                OFF_SP_LO: state_next.rdata = state_reg.sp[31:0];
                OFF_SP_HI: state_next.rdata = state_reg.sp[63:32];
                OFF_CS: state_next.rdata = {16'h0, state_reg.cs};
                OFF_IP_LO: state_next.rdata = state_reg.ip[31:0];
                OFF_IP_HI: state_next.rdata = state_reg.ip[63:32];
                default:
                begin
                    if (stk_hit && paddr[3:2] == STK_WORD_LO)
                        state_next.rdata = apb_sp[31:0];
                    else if (stk_hit && paddr[3:2] == STK_WORD_HI)
                        state_next.rdata = apb_sp[63:32];
                    else if (stk_hit)
                        state_next.rdata = {16'h0, entry_sel(state_reg, lvl)};
                    else
                        state_next.slverr = 1'b1;
                end
            endcase
        end

        // configuration is frozen while a transfer runs
        if (psel && penable && pwrite && !state_reg.busy)
        begin
            case (paddr)
                OFF_CTRL:
                begin
                    state_next.long_mode = pwdata[CTRL_LONG];
                    state_next.is_jump = pwdata[CTRL_JUMP];
                    state_next.conforming = pwdata[CTRL_CONF];
                    state_next.gate32 = pwdata[CTRL_GATE32];
                    state_next.tgt64 = pwdata[CTRL_TGT64];
                    if (pwdata[CTRL_START])
                    begin
                        state_next.phase = P_CHECK;
                        state_next.busy = 1'b1;
                        state_next.done = 1'b0;
                        state_next.fault = 1'b0;
                        state_next.failed = 3'h0;
                    end
                end
                OFF_PRIV:
                begin
                    state_next.current_privilege_level = pwdata[PRIV_CUR +: 2];
                    state_next.requested_privilege = pwdata[PRIV_REQ +: 2];
                    state_next.gpriv = pwdata[PRIV_GATE +: 2];
                    state_next.tpriv = pwdata[PRIV_TGT +: 2];
                    state_next.count = pwdata[PRIV_CNT +: 5];
                end
                OFF_GSEL: state_next.gsel = pwdata[15:0];
                OFF_GOFF_LO: state_next.goff[31:0] = pwdata;
                OFF_GOFF_HI: state_next.goff[63:32] = pwdata;
                OFF_SS: state_next.ss = pwdata[15:0];
                OFF_SP_LO: state_next.sp[31:0] = pwdata;
                OFF_SP_HI: state_next.sp[63:32] = pwdata;
                OFF_CS: state_next.cs = pwdata[15:0];
                OFF_IP_LO: state_next.ip[31:0] = pwdata;
                OFF_IP_HI: state_next.ip[63:32] = pwdata;
                default:
                begin
                    if (stk_hit && paddr[3:2] == STK_WORD_LO)
                        state_next.lvl_sp[lvl][31:0] = pwdata;
                    else if (stk_hit && paddr[3:2] == STK_WORD_HI)
                        state_next.lvl_sp[lvl][63:32] = pwdata;
                    else if (stk_hit && paddr[3:2] == STK_WORD_SEL)
                        state_next.lvl_sel[lvl] = pwdata[15:0];
                end
            endcase
        end

        case (state_reg.phase)
            P_PUSH_SS:
            begin
                pval = {48'h0, state_reg.ss};
                after = P_PUSH_SP;
            end
            P_PUSH_SP:
            begin
                pval = state_reg.long_mode ? state_reg.sp : {32'h0, state_reg.sp[31:0]};
                // long mode never copies parameters
                after = (!state_reg.long_mode && state_reg.count != 5'h0) ? P_READ
                                                                           : P_PUSH_CS;
            end
            P_PUSH_PARAM:
            begin
                pval = state_reg.pdata;
                after = (state_reg.idx == 5'h1) ? P_PUSH_CS : P_READ;
            end
            P_PUSH_CS:
            begin
                pval = {48'h0, state_reg.cs};
                after = P_PUSH_IP;
            end
            P_PUSH_IP:
            begin
                pval = state_reg.long_mode ? state_reg.ip : {32'h0, state_reg.ip[31:0]};
                after = P_COMMIT;
            end
            default:
            begin
                pval = 64'h0;
                after = P_IDLE;
            end
        endcase

        case (state_reg.phase)
            P_IDLE:
            begin
                state_next.mem_req = 1'b0;
            end
            P_CHECK:
            begin
                // all three checks are finished before any selector is touched
                if (pc.pass != ALL_PASS
                    || (state_reg.long_mode && (!state_reg.tgt64 || !state_reg.gate32)))
                begin
                    state_next.fault = 1'b1;
                    state_next.done = 1'b1;
                    state_next.busy = 1'b0;
                    state_next.failed = ~pc.pass;
                    state_next.phase = P_IDLE;
                end
                else if (!state_reg.is_jump && !state_reg.conforming
                    && state_reg.tpriv < state_reg.current_privilege_level)
                begin
                    state_next.change = 1'b1;
                    state_next.new_priv = state_reg.tpriv;
                    state_next.wsp = state_reg.long_mode ? tgt_sp
                        : {32'h0, tgt_sp[31:0]};
                    state_next.idx = state_reg.count;
                    state_next.phase = P_PUSH_SS;
                end
                else
                begin
                    state_next.change = 1'b0;
                    state_next.new_priv = state_reg.current_privilege_level;
                    state_next.wsp = state_reg.sp;
                    state_next.phase = state_reg.is_jump ? P_COMMIT : P_PUSH_CS;
                end
            end
            P_READ:
            begin
                // parameter count lies highest on the old stack and is pushed first
                if (!state_reg.mem_req)
                begin
                    state_next.mem_req = 1'b1;
                    state_next.mem_we = 1'b0;
                    state_next.mem_size = 4'(psz);
                    state_next.mem_addr = {32'h0, state_reg.sp[31:0]}
                        + ({59'h0, 5'(state_reg.idx - 5'h1)} << sh);
                end
                else if (mem_ready)
                begin
                    state_next.mem_req = 1'b0;
                    state_next.pdata = state_reg.gate32 ? {32'h0, mem_rdata[31:0]}
                        : {48'h0, mem_rdata[15:0]};
                    state_next.phase = P_PUSH_PARAM;
                end
            end
            P_COMMIT:
            begin
                state_next.current_privilege_level = state_reg.new_priv;
                state_next.cs = {state_reg.gsel[15:2], state_reg.new_priv};
                if (state_reg.long_mode)
                    state_next.ip = state_reg.goff;
                else if (state_reg.gate32)
                    state_next.ip = {32'h0, state_reg.goff[31:0]};
                else
                    state_next.ip = {48'h0, state_reg.goff[15:0]};
                if (state_reg.change)
                begin
                    state_next.ss = state_reg.long_mode ? {NULL_SEL[15:2], state_reg.new_priv}
                        : {tgt_sel[15:2], state_reg.new_priv};
                end
                state_next.sp = state_reg.wsp;
                state_next.busy = 1'b0;
                state_next.done = 1'b1;
                state_next.phase = P_IDLE;
            end
            default:
            begin
                // every push: hold the request until the memory takes it
                if (!state_reg.mem_req)
                begin
                    state_next.mem_req = 1'b1;
                    state_next.mem_we = 1'b1;
                    state_next.mem_addr = state_reg.wsp - psz;
                    state_next.mem_wdata = pval;
                    state_next.mem_size = 4'(psz);
                end
                else if (mem_ready)
                begin
                    state_next.mem_req = 1'b0;
                    state_next.wsp = state_reg.mem_addr;
                    if (state_reg.phase == P_PUSH_PARAM)
                        state_next.idx = 5'(state_reg.idx - 5'h1);
                    state_next.phase = after;
                end
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign prdata = state_reg.rdata;
    assign pslverr = psel && penable && state_reg.slverr;
    assign pready = psel && penable;
    assign mem_req = state_reg.mem_req;
    assign mem_we = state_reg.mem_we;
    assign mem_addr = state_reg.mem_addr;
    assign mem_wdata = state_reg.mem_wdata;
    assign mem_size = state_reg.mem_size;
    assign gate_busy = state_reg.busy;
    assign gate_fault = state_reg.fault;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_CHK_GATE: assert property (
        state_reg.phase == P_CHECK && state_reg.current_privilege_level > state_reg.gpriv
        |=> gate_fault
    ) else $error("current privilege above gate privilege not denied");
    AST_CHK_REQ: assert property (
        state_reg.phase == P_CHECK && state_reg.requested_privilege > state_reg.gpriv
        |=> gate_fault
    ) else $error("requested privilege above gate privilege not denied");
    AST_CHK_CALL: assert property (
        state_reg.phase == P_CHECK && !state_reg.is_jump
        && state_reg.current_privilege_level < state_reg.tpriv
        |=> gate_fault && state_reg.failed[2]
    ) else $error("call to less privileged target not denied");
    AST_CHK_JUMP: assert property (
        state_reg.phase == P_CHECK && state_reg.is_jump && !state_reg.conforming
        && state_reg.current_privilege_level != state_reg.tpriv |=> gate_fault
    ) else $error("nonconforming jump with unequal privilege not denied");
    AST_DENY_KEEPS: assert property (
        state_reg.phase == P_CHECK && pc.pass != ALL_PASS
        |=> state_reg.phase == P_IDLE && $stable(state_reg.cs) && $stable(state_reg.ip)
            && $stable(state_reg.sp) && $stable(state_reg.ss) && !mem_req
    ) else $error("denied transfer changed state");
    AST_LONG_TARGET: assert property (
        state_reg.phase == P_CHECK && state_reg.long_mode && !state_reg.tgt64 |=> gate_fault
    ) else $error("long gate to non 64-bit target accepted");
    AST_LONG_16: assert property (
        state_reg.phase == P_CHECK && state_reg.long_mode && !state_reg.gate32 |=> gate_fault
    ) else $error("16-bit gate accepted in long mode");
    AST_PUSH8: assert property (
        mem_req && mem_we && state_reg.long_mode |-> mem_size == 4'h8
            && mem_addr == state_reg.wsp - 64'h8
    ) else $error("long push not eight bytes");
    AST_NO_COPY: assert property (
        state_reg.long_mode |-> state_reg.phase != P_READ
    ) else $error("long mode copied parameters");
    AST_NULL_SS: assert property (
        state_reg.phase == P_COMMIT && state_reg.long_mode && state_reg.change
        |=> state_reg.ss == {14'h0, state_reg.current_privilege_level}
            && state_reg.ip == $past(state_reg.goff)
    ) else $error("long stack switch selector or target wrong");
    AST_HOLD: assert property (
        mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_wdata)
    ) else $error("memory request dropped before taken");

    COV_FAULT: cover property (state_reg.phase == P_CHECK ##1 gate_fault);
    COV_LEGACY_PARAM: cover property (state_reg.phase == P_PUSH_PARAM && mem_req && mem_ready);
    COV_LONG_SWITCH: cover property (state_reg.phase == P_COMMIT && state_reg.long_mode
        && state_reg.change);
    COV_JUMP: cover property (state_reg.phase == P_COMMIT && state_reg.is_jump);
endmodule : call_gate_unit

// ==== test_call_gate_privilege_stack_switch.sv ====
module test_call_gate_privilege_stack_switch import gate_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] c, r, g, t; logic j, k; logic [2:0] e;} row_t;
    logic mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic mem_ready = 1'h0, pready, pslverr, mem_req, mem_we, gate_busy, gate_fault, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [63:0] mem_addr, mem_wdata, mem_rdata;
    logic [3:0] mem_size;
    logic [63:0] la[$], ld[$];
    logic [3:0] ls[$];
    int errors = 0, compares = 0, nrd = 0;
    // check n failed sets bit n-1 of the expected field
    row_t rows[10] = '{'{3,3,3,0,0,0,0}, '{2,3,0,3,0,0,7}, '{1,1,1,1,0,0,0}, '{2,0,1,0,0,0,1},
        '{0,2,1,0,0,0,2}, '{1,0,3,2,0,0,4}, '{2,0,3,1,1,0,4}, '{2,0,3,1,1,1,0}, '{1,0,3,1,1,0,0},
        '{2,0,3,1,0,1,0}};
    always #5 mclk = ~mclk;
    // read data tied to address so parameter copies are traceable
    assign mem_rdata = {32'h0, mem_addr[31:0] ^ 32'h0000_5A5A};
    call_gate_unit DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .gate_busy(gate_busy), .gate_fault(gate_fault));
    // memory stalls every other cycle
    always @(posedge mclk) mem_ready <= ~mem_ready;
    always @(posedge mclk)
    begin
        if (mem_req === 1'h1 && mem_ready === 1'h1 && mem_we === 1'h1)
        begin
            la.push_back(mem_addr);
            ld.push_back(mem_wdata);
            ls.push_back(mem_size);
        end
        if (mem_req === 1'h1 && mem_ready === 1'h1 && mem_we === 1'h0)
            nrd++;
    end
    task close_out;
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge mclk);
            if (pready === 1'h1)
                break;
        end
        if (n == 20)
        begin
            errors++;
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task rchk(input logic [7:0] a, input logic [63:0] x);
        apb(1'h0, a, 32'h0);
        cmp(q, x);
    endtask : rchk
    task run(input logic [31:0] ctrl);
        int n;
        apb(1'h1, OFF_CTRL, ctrl | 32'h1);
        // busy may rise one edge late, so skip two edges first
        repeat (2) @(posedge mclk);
        for (n = 0; n < 400 && gate_busy !== 1'h0; n++)
            @(posedge mclk);
        if (n == 400)
        begin
            errors++;
            close_out();
        end
    endtask : run
    task cfg(input logic [31:0] pr, ghi, splo, input logic [7:0] ent, input logic [31:0] elo, ehi);
        logic [39:0] t[13];
        t = '{{OFF_PRIV, pr}, {OFF_GSEL, 32'h10}, {OFF_GOFF_LO, 32'h2222}, {OFF_GOFF_HI, ghi},
            {OFF_SS, 32'h2B}, {OFF_SP_LO, splo}, {OFF_SP_HI, 32'h0}, {OFF_CS, 32'h1B},
            {OFF_IP_LO, 32'h4444}, {OFF_IP_HI, 32'h0}, {ent, elo}, {ent + 8'h04, ehi},
            {ent + 8'h08, 32'h28}};
        foreach (t[i])
            apb(1'h1, t[i][39:32], t[i][31:0]);
        la.delete();
        ld.delete();
        ls.delete();
        nrd = 0;
    endtask : cfg
    task pchk(input int i, input logic [63:0] a, d, input logic [3:0] s);
        cmp(la[i], a);
        cmp(ld[i], d);
        cmp(ls[i], s);
    endtask : pchk
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        cmp({gate_busy, gate_fault}, 2'h0);
        rchk(OFF_STATUS, 64'h0);
        apb(1'h0, 8'h60, 32'h0);
        cmp({e, q}, {1'h1, 32'h0});
        foreach (rows[i])
        begin
            apb(1'h1, OFF_PRIV, {24'h0, rows[i].t, rows[i].g, rows[i].r, rows[i].c});
            run({27'h0, 1'h1, rows[i].k, rows[i].j, 2'h0});
            apb(1'h0, OFF_STATUS, 32'h0);
            cmp(q[6:4], rows[i].e);
            cmp(gate_fault, rows[i].e != 3'h0);
            cmp(q[9:8], (rows[i].e != 3'h0 || rows[i].j || rows[i].k || rows[i].t >= rows[i].c)
                ? rows[i].c : rows[i].t);
        end
        // legacy 32-bit gate, two parameters, privilege 3 to 0
        cfg(32'h23F, 32'h0, 32'h8000, 8'h30, 32'h1000, 32'h0);
        run(32'h10);
        cmp({la.size(), nrd}, {32'd6, 32'd2});
        pchk(0, 64'h0FFC, 64'h2B, 4'h4);
        pchk(1, 64'h0FF8, 64'h8000, 4'h4);
        pchk(2, 64'h0FF4, 64'hDA5E, 4'h4);
        pchk(3, 64'h0FF0, 64'hDA5A, 4'h4);
        pchk(4, 64'h0FEC, 64'h1B, 4'h4);
        pchk(5, 64'h0FE8, 64'h4444, 4'h4);
        rchk(OFF_SS, 64'h28);
        rchk(OFF_SP_LO, 64'h0FE8);
        rchk(OFF_CS, 64'h10);
        rchk(OFF_IP_LO, 64'h2222);
        // long mode, count 5 must be ignored, privilege 3 to 1
        cfg(32'h57F, 32'h7, 32'h9000, 8'h40, 32'h3000, 32'h1);
        run(32'h32);
        cmp({la.size(), nrd}, {32'd4, 32'd0});
        pchk(0, 64'h1_0000_2FF8, 64'h2B, 4'h8);
        pchk(1, 64'h1_0000_2FF0, 64'h9000, 4'h8);
        pchk(2, 64'h1_0000_2FE8, 64'h1B, 4'h8);
        pchk(3, 64'h1_0000_2FE0, 64'h4444, 4'h8);
        rchk(OFF_SS, 64'h1);
        rchk(OFF_SP_LO, 64'h2FE0);
        rchk(OFF_SP_HI, 64'h1);
        rchk(OFF_CS, 64'h11);
        rchk(OFF_IP_LO, 64'h2222);
        rchk(OFF_IP_HI, 64'h7);
        // target not 64-bit, then a 16-bit gate, both in long mode
        foreach (rows[i])
        begin
            if (i < 2)
            begin
                la.delete();
                run(i == 0 ? 32'h12 : 32'h22);
                cmp({gate_fault, la.size()}, {1'h1, 32'd0});
                rchk(OFF_CS, 64'h11);
            end
        end
        // legacy 16-bit gate, one parameter, privilege 3 to 2
        cfg(32'h1BF, 32'h0, 32'h18000, 8'h50, 32'h2000, 32'h0);
        run(32'h0);
        cmp({la.size(), nrd}, {32'd5, 32'd1});
        pchk(0, 64'h1FFE, 64'h2B, 4'h2);
        pchk(2, 64'h1FFA, 64'hDA5A, 4'h2);
        pchk(4, 64'h1FF6, 64'h4444, 4'h2);
        rchk(OFF_SS, 64'h2A);
        rchk(OFF_SP_LO, 64'h1FF6);
        rchk(OFF_CS, 64'h12);
        close_out();
    end
endmodule : test_call_gate_privilege_stack_switch
